// [pdcb_pkg.sv]
// Package holding the divider configuration bank map, defaults and carriers
package pdcb_pkg;

    // =========================================================
    // Register port geometry
    localparam int          PDCB_DATA_W   = 8;
    localparam int          PDCB_ADDR_W   = 8;
    localparam int          PDCB_NUM_REGS = 11;
    localparam int          PDCB_IDX_W    = 4;

    // =========================================================
    // Register offsets
    localparam logic [7:0] OFS_SYNTH_A_INT_DIVIDER_LOW        = 8'h09;
    localparam logic [7:0] OFS_SYNTH_A_LOOP_FILTER_DIV_HIGH   = 8'h0a;
    localparam logic [7:0] OFS_SYNTH_A_CHARGE_PUMP_GAIN       = 8'h0b;
    localparam logic [7:0] OFS_SYNTH_A_SPREAD_REF_DIVIDER     = 8'h0c;
    localparam logic [7:0] OFS_SYNTH_A_SPREAD_FB_DIVIDER_HIGH = 8'h0d;
    localparam logic [7:0] OFS_SYNTH_A_SPREAD_FB_DIVIDER_LOW  = 8'h0e;
    localparam logic [7:0] OFS_OUTPUT_DIVIDER_PAIR            = 8'h0f;
    localparam logic [7:0] OFS_SYNTH_B_INT_DIVIDER_HIGH       = 8'h10;
    localparam logic [7:0] OFS_SYNTH_B_INT_DIVIDER_LOW        = 8'h11;
    localparam logic [7:0] OFS_SYNTH_B_FRAC_DIVIDER_HIGH      = 8'h12;
    localparam logic [7:0] OFS_SYNTH_B_FRAC_DIVIDER_LOW       = 8'h13;

    // First and last mapped offsets
    localparam logic [7:0] OFS_FIRST = OFS_SYNTH_A_INT_DIVIDER_LOW;
    localparam logic [7:0] OFS_LAST  = OFS_SYNTH_B_FRAC_DIVIDER_LOW;

    // =========================================================
    // Power-up defaults, index 0 (offset 0x09) in the low byte
    localparam logic [PDCB_NUM_REGS*8-1:0] RESET_TABLE = {
        8'h00,  // 0x13 fraction low
        8'h00,  // 0x12 fraction high
        8'h3c,  // 0x11 synth b integer low (60)
        8'h00,  // 0x10 synth b integer high
        8'h33,  // 0x0f output dividers 0011 / 0011
        8'h00,  // 0x0e spread feedback low
        8'h00,  // 0x0d spread feedback high
        8'h00,  // 0x0c spread reference
        8'h06,  // 0x0b x1 and divide-by-24
        8'hb2,  // 0x0a loop filter, integer 10:8 (600)
        8'h58   // 0x09 synth a integer low (600)
    };

    // Writable bits; reserved bits stay zero
    localparam logic [PDCB_NUM_REGS*8-1:0] WMASK_TABLE = {
        8'hff, 8'hff, 8'hff, 8'h07, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff
    };

    // =========================================================
    // Field positions
    localparam int POS_RES_HUNDRED     = 7;
    localparam int POS_RES_FIFTY       = 6;
    localparam int POS_RES_TWENTYFIVE  = 5;
    localparam int POS_RES_TWELVE_HALF = 4;
    localparam int POS_RES_ONE_ONLY    = 3;
    localparam int POS_PUMP_DIV_24     = 1;
    localparam int POS_PUMP_DIV_3      = 0;
    localparam int POS_SPREAD_REF_CTRL = 7;
    // Multi-bit fields: lowest bit and width inside their byte
    localparam int POS_INT_UPPER       = 0;
    localparam int W_INT_UPPER         = 3;
    localparam int POS_PUMP_GAIN       = 2;
    localparam int W_PUMP_GAIN         = 6;
    localparam int POS_SPREAD_REF      = 0;
    localparam int W_SPREAD_REF        = 7;
    localparam int POS_OUT_DIV_ONE     = 4;
    localparam int POS_OUT_DIV_TWO     = 0;
    localparam int W_OUT_DIV           = 4;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic        synth_a_loop_res_hundred;
        logic        synth_a_loop_res_fifty;
        logic        synth_a_loop_res_twentyfive;
        logic        synth_a_loop_res_twelve_half;
        logic        synth_a_loop_res_one_only;
        logic [10:0] fb_integer;
        logic [5:0]  pump_gain;      // x32 .. x1, MSB first
        logic        synth_a_pump_div_24;
        logic        synth_a_pump_div_3;
        logic        synth_a_spread_ref_ctrl_bit;
        logic [6:0]  synth_a_spread_ref_divider;
        logic [15:0] synth_a_spread_fb_divider;
    } pdcb_synth_a_t;

    typedef struct packed {
        logic [3:0]  output_divider_one;
        logic [3:0]  output_divider_two;
    } pdcb_out_div_t;

    typedef struct packed {
        logic [2:0]  synth_b_fb_integer_upper;
        logic [7:0]  synth_b_fb_integer_lower;
        logic [15:0] synth_b_fb_fraction;
    } pdcb_synth_b_t;

endpackage

// [pdcb_byte_reg.sv]
// One configuration byte with power-up default and writable-bit mask
`timescale 1ns/1ps
module pdcb_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WMASK     = 8'hff
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    // Write port
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wdata_i,
    // Stored value
    output logic      [7:0] value_o
);

    // =========================================================
    // Storage
    // Masked bits keep their default, which is zero for reserved bits
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            value_o <= RESET_VAL;
        end else if (wr_en_i) begin
            value_o <= (wdata_i & WMASK) | (value_o & ~WMASK);
        end
    end

endmodule

// [pdcb_bank.sv]
// Byte-wide divider configuration bank for the clock synthesizers
// Behaviour
// - Bits 7..4 at 0x0a add loop resistors
// - Bit 3 at 0x0a selects 1k only
// - 0x0a bits 2..0 are divider 10:8
// - 0x09 holds divider low byte
// - 0x0b pump gains and divide terms
// - 0x0c spread reference divider plus control
// - 0x0d/0x0e form spread feedback divider
// - 0x0f high nibble is output divider one
// - 0x0f low nibble is output divider two
// - 0x10/0x11 form second integer divider
// - 0x12 is fraction high byte
// - 0x13 is fraction low byte
`timescale 1ns/1ps
module pdcb_bank #(
    parameter int NUM_REGS = pdcb_pkg::PDCB_NUM_REGS
) (
    // Clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          rst_b_i,
    // Byte register port from the serial engine
    input  wire logic                          wr_en_i,
    input  wire logic                          rd_en_i,
    input  wire logic [pdcb_pkg::PDCB_ADDR_W-1:0] addr_i,
    input  wire logic [pdcb_pkg::PDCB_DATA_W-1:0] wdata_i,
    output logic      [pdcb_pkg::PDCB_DATA_W-1:0] rdata_o,
    output logic                               rd_valid_o,
    // Decoded settings toward the analog loops
    output pdcb_pkg::pdcb_synth_a_t            synth_a_o,
    output pdcb_pkg::pdcb_out_div_t            out_div_o,
    output pdcb_pkg::pdcb_synth_b_t            synth_b_o
);
    import pdcb_pkg::*;

    // =========================================================
    // Address decode
    // Reads and writes share one address, so one decode serves both
    // Offsets outside the bank match nothing and are dropped
    // True when the offset lands inside the bank
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a >= OFS_FIRST) && (a <= OFS_LAST);
    endfunction

    // Bank index of an offset
    // Only meaningful while addr_hit is true; the spare codes of
    // the index never select a byte
    function automatic logic [PDCB_IDX_W-1:0] addr_index(
        input logic [7:0] a);
        logic [7:0] d;
        d = a - OFS_FIRST;
        addr_index = d[PDCB_IDX_W-1:0];
    endfunction

    // Bank state and write decode
    logic [7:0]            regs [NUM_REGS];  // Stored bytes
    logic [NUM_REGS-1:0]   wr_sel;           // Per-byte write strobe
    logic                  wr_hit;           // Write lands in bank
    logic [PDCB_IDX_W-1:0] wr_idx;           // Write byte index

    assign wr_hit = addr_hit(addr_i);
    assign wr_idx = addr_index(addr_i);

    // =========================================================
    // Byte storage
    // One strobe per byte; unmapped writes touch nothing
    // Each byte carries its own default and writable-bit mask,
    // so reserved bits keep reading zero whatever is written
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g = g + 1) begin : g_byte
            assign wr_sel[g] = wr_en_i && wr_hit
                               && (wr_idx == PDCB_IDX_W'(g));
            pdcb_byte_reg #(
                .RESET_VAL (RESET_TABLE[g*8 +: 8]),
                .WMASK     (WMASK_TABLE[g*8 +: 8])
            ) u_byte (
                .clock_i (clock_i),
                .rst_b_i (rst_b_i),
                .wr_en_i (wr_sel[g]),
                .wdata_i (wdata_i),
                .value_o (regs[g])
            );
        end
    endgenerate

    // =========================================================
    // Bank index constants
    // Each mapped offset as a slot in the byte array; worked out
    // from the offset table so a moved offset needs no edit here
    // First synthesizer integer divider, low byte
    localparam int I09 = int'(OFS_SYNTH_A_INT_DIVIDER_LOW - OFS_FIRST);
    // Loop filter selects with integer divider upper bits
    localparam int I0A = int'(OFS_SYNTH_A_LOOP_FILTER_DIV_HIGH - OFS_FIRST);
    // Charge pump weights and divide terms
    localparam int I0B = int'(OFS_SYNTH_A_CHARGE_PUMP_GAIN - OFS_FIRST);
    // Spread spectrum reference divider
    localparam int I0C = int'(OFS_SYNTH_A_SPREAD_REF_DIVIDER - OFS_FIRST);
    // Spread spectrum feedback divider, high then low byte
    localparam int I0D = int'(OFS_SYNTH_A_SPREAD_FB_DIVIDER_HIGH - OFS_FIRST);
    localparam int I0E = int'(OFS_SYNTH_A_SPREAD_FB_DIVIDER_LOW - OFS_FIRST);
    // Output divider pair
    localparam int I0F = int'(OFS_OUTPUT_DIVIDER_PAIR - OFS_FIRST);
    // Second synthesizer integer divider, upper then low byte
    localparam int I10 = int'(OFS_SYNTH_B_INT_DIVIDER_HIGH - OFS_FIRST);
    localparam int I11 = int'(OFS_SYNTH_B_INT_DIVIDER_LOW - OFS_FIRST);
    // Second synthesizer fraction, high then low byte
    localparam int I12 = int'(OFS_SYNTH_B_FRAC_DIVIDER_HIGH - OFS_FIRST);
    localparam int I13 = int'(OFS_SYNTH_B_FRAC_DIVIDER_LOW - OFS_FIRST);

    // =========================================================
    // Read port
    // Registered read; unmapped offsets answer zero
    // The answer is picked before the edge, so a write to the same
    // byte in the same cycle shows up only on the following read
    logic [PDCB_DATA_W-1:0] next_rdata;  // Byte the next read returns

    // Read mux on the shared address decode
    always_comb begin
        // Unmapped offsets answer zero
        next_rdata = 8'h00;
        if (wr_hit) begin
            // Mapped offset: stored byte, reserved bits already zero
            next_rdata = regs[wr_idx];
        end
    end

    // Read data register; holds until the next read strobe
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            // Reset clears the answer
            rdata_o <= 8'h00;
        end else if (rd_en_i) begin
            // Load on every read strobe
            rdata_o <= next_rdata;
        end
    end

    // One-cycle marker that read data is fresh
    // Follows the read strobe one edge late and drops after one
    // cycle, since each strobe is a single-cycle pulse
    // The host picks up rdata_o while this marker stands
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
        end
    end

    // =========================================================
    // First synthesizer settings
    // Every field is wired straight from a byte flop, so a setting
    // moves on the edge after its byte is written
    // Loop filter resistor selects; a set bit adds its resistor,
    // a clear bit bypasses it, and the one-only select leaves
    // just the small fixed resistance in the filter
    assign synth_a_o.synth_a_loop_res_hundred =
        regs[I0A][POS_RES_HUNDRED];
    assign synth_a_o.synth_a_loop_res_fifty =
        regs[I0A][POS_RES_FIFTY];
    assign synth_a_o.synth_a_loop_res_twentyfive =
        regs[I0A][POS_RES_TWENTYFIVE];
    assign synth_a_o.synth_a_loop_res_twelve_half =
        regs[I0A][POS_RES_TWELVE_HALF];
    assign synth_a_o.synth_a_loop_res_one_only =
        regs[I0A][POS_RES_ONE_ONLY];
    // Integer feedback divider, upper three then low byte
    // The halves live in two bytes with no shadow, so the loop
    // sees a mixed value until the host has written both
    // Values below twelve are not refused; the host avoids them
    assign synth_a_o.fb_integer =
        {regs[I0A][POS_INT_UPPER +: W_INT_UPPER],
         regs[I09]};
    // Charge pump weights and divide terms
    // Weights run from x32 in the top bit down to x1; reset
    // leaves x1 with the divide-by-24 term
    assign synth_a_o.pump_gain =
        regs[I0B][POS_PUMP_GAIN +: W_PUMP_GAIN];
    assign synth_a_o.synth_a_pump_div_24 =
        regs[I0B][POS_PUMP_DIV_24];
    assign synth_a_o.synth_a_pump_div_3 =
        regs[I0B][POS_PUMP_DIV_3];
    // Spread spectrum dividers
    // All clear at reset; the feedback divider shares the
    // two-byte update hazard of the integer divider
    assign synth_a_o.synth_a_spread_ref_ctrl_bit =
        regs[I0C][POS_SPREAD_REF_CTRL];
    assign synth_a_o.synth_a_spread_ref_divider =
        regs[I0C][POS_SPREAD_REF +: W_SPREAD_REF];
    assign synth_a_o.synth_a_spread_fb_divider =
        {regs[I0D], regs[I0E]};

    // =========================================================
    // Output dividers
    // Two independent nibbles sharing one byte; a single write
    // updates both at once, and both power up at the same code
    // Upper nibble
    assign out_div_o.output_divider_one =
        regs[I0F][POS_OUT_DIV_ONE +: W_OUT_DIV];
    // Lower nibble
    assign out_div_o.output_divider_two =
        regs[I0F][POS_OUT_DIV_TWO +: W_OUT_DIV];

    // =========================================================
    // Second synthesizer settings
    // Integer divider upper bits; the reserved top of that byte
    // is masked at the write and never reaches the loop
    assign synth_b_o.synth_b_fb_integer_upper =
        regs[I10][POS_INT_UPPER +: W_INT_UPPER];
    // Integer divider low byte
    assign synth_b_o.synth_b_fb_integer_lower =
        regs[I11];
    // Fraction, high byte then low byte
    // A fraction change takes two writes; the loop sees the
    // half-updated value in between
    assign synth_b_o.synth_b_fb_fraction =
        {regs[I12],
         regs[I13]};

endmodule

// [pdcb_bank_monitor.sv]
// Concurrent checks on the divider bank register port and settings
`timescale 1ns/1ps
module pdcb_bank_monitor (
    // Clock and reset
    input wire logic                    clock_i,
    input wire logic                    rst_b_i,
    // Register port
    input wire logic                    wr_en_i,
    input wire logic                    rd_en_i,
    input wire logic [7:0]              addr_i,
    input wire logic [7:0]              wdata_i,
    input wire logic [7:0]              rdata_o,
    input wire logic                    rd_valid_o,
    // Decoded settings
    input wire pdcb_pkg::pdcb_synth_a_t synth_a_o,
    input wire pdcb_pkg::pdcb_out_div_t out_div_o,
    input wire pdcb_pkg::pdcb_synth_b_t synth_b_o
);
    import pdcb_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // ==========================================================
    // Settings follow the written byte one cycle later; a read of 0x10 returns its reserved bits as zero
    property p_filt;
        wr_en_i && addr_i == 8'h0a |=> synth_a_o[47:40] == $past(wdata_i);
    endproperty
    a_filt: assert property (p_filt)
        else $error("loop filter byte");
    property p_intlo;
        wr_en_i && addr_i == 8'h09 |=> synth_a_o[39:32] == $past(wdata_i);
    endproperty
    a_intlo: assert property (p_intlo) else $error("integer low");
    property p_pump;
        wr_en_i && addr_i == 8'h0b |=> synth_a_o[31:24] == $past(wdata_i);
    endproperty
    a_pump: assert property (p_pump) else $error("pump byte");
    property p_sref;
        wr_en_i && addr_i == 8'h0c |=> synth_a_o[23:16] == $past(wdata_i);
    endproperty
    a_sref: assert property (p_sref) else $error("spread ref");
    property p_sfb;
        wr_en_i && addr_i == 8'h0d |=> synth_a_o[15:8] == $past(wdata_i);
    endproperty
    a_sfb: assert property (p_sfb) else $error("spread fb high");
    property p_odiv;
        wr_en_i && addr_i == 8'h0f |=> out_div_o == $past(wdata_i);
    endproperty
    a_odiv: assert property (p_odiv)
        else $error("output dividers");
    property p_frac;
        wr_en_i && addr_i == 8'h12 |=> synth_b_o[15:8] == $past(wdata_i);
    endproperty
    a_frac: assert property (p_frac) else $error("fraction high");
    property p_intbh;
        wr_en_i && addr_i == 8'h10
            |=> synth_b_o[26:24] == $past(wdata_i[2:0]);
    endproperty
    a_intbh: assert property (p_intbh)
        else $error("integer b high");
    property p_intbl;
        wr_en_i && addr_i == 8'h11 |=> synth_b_o[23:16] == $past(wdata_i);
    endproperty
    a_intbl: assert property (p_intbl) else $error("integer b low");
    property p_rsv;
        rd_en_i && addr_i == 8'h10 |=> rd_valid_o && rdata_o[7:3] == 5'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    // Read valid follows the read strobe one cycle late; output divider and second synthesizer settings hold without a write
    property p_rdv;
        1'b1 |=> rd_valid_o == $past(rd_en_i);
    endproperty
    a_rdv: assert property (p_rdv) else $error("read valid timing");
    property p_hold;
        !wr_en_i |=> $stable(out_div_o) && $stable(synth_b_o);
    endproperty
    a_hold: assert property (p_hold) else $error("setting moved");
endmodule

// [pdcb_host_model.sv]
// Behavioural serial host issuing byte accesses to the bank
`timescale 1ns/1ps
module pdcb_host_model (
    // Clock
    input  wire logic       clock_i,
    // Read answer from the bank
    input  wire logic [7:0] rdata_i,
    input  wire logic       rd_valid_i,
    // Byte requests toward the bank
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    int unsigned idle_cycles = 0;   // Slow host: idle cycles before each write
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end
    // One byte write; wide fields go as a run of these
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat (idle_cycles) @(negedge clock_i);
        @(negedge clock_i);
        wr_en_o = 1'b1;
        addr_o  = a;
        wdata_o = d;
        @(negedge clock_i);
        wr_en_o = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;   // Released lines never keep the last value
    endtask
    // One byte read; answer picked up mid-cycle after the take edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(negedge clock_i);
        rd_en_o = 1'b1;
        addr_o  = a;
        @(negedge clock_i);
        rd_en_o = 1'b0;
        addr_o  = ~a;
        d = rdata_i;
        v = rd_valid_i;
    endtask
endmodule

// [test_pdcb_bank.sv]
// Self-checking bench for the divider configuration bank
`timescale 1ns/1ps
`define CHK(got, want) begin n_tests++; if ((got) !== (want)) begin \
    fail_count++; $display("Error t=%0t got %h exp %h", $time, got, want); \
    end end
module test_pdcb_bank;
    import pdcb_pkg::*;
    // ==========================================================
    // Clock, reset, wiring and expected bytes
    logic          clock_i = 1'b0;
    logic          rst_b_i = 1'b0;
    logic          wr_en, rd_en, rd_valid;
    logic [7:0]    addr, wdata, rdata;
    pdcb_synth_a_t synth_a;
    pdcb_out_div_t out_div;
    pdcb_synth_b_t synth_b;
    logic [7:0]    shadow [0:255];   // Expected byte per offset
    int            fail_count = 0;
    int            n_tests = 0;
    int            cycles = 0;
    always #12.5 clock_i = ~clock_i;
    pdcb_host_model i_host (.clock_i(clock_i), .rdata_i(rdata),
        .rd_valid_i(rd_valid), .wr_en_o(wr_en), .rd_en_o(rd_en),
        .addr_o(addr), .wdata_o(wdata));
    pdcb_bank i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
        .rd_valid_o(rd_valid), .synth_a_o(synth_a), .out_div_o(out_div),
        .synth_b_o(synth_b));
    // Power-up byte and writable bits per offset
    function automatic logic [7:0] dflt(input logic [7:0] a);
        case (a)
            8'h09: return 8'h58;
            8'h0a: return 8'hb2;
            8'h0b: return 8'h06;
            8'h0f: return 8'h33;
            8'h11: return 8'h3c;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] wmask(input logic [7:0] a);
        if (a < 8'h09 || a > 8'h13) return 8'h00;   // Unmapped
        return (a == 8'h10) ? 8'h07 : 8'hff;
    endfunction
    task automatic reset_bank();
        rst_b_i = 1'b0;
        repeat (4) @(negedge clock_i);
        rst_b_i = 1'b1;
        for (int a = 0; a < 256; a++) shadow[a] = dflt(8'(a));
    endtask
    task automatic check_outputs();
        logic [47:0] exp_a;   // Expected first synthesizer settings
        logic [26:0] exp_b;   // Expected second synthesizer settings
        exp_a = {shadow[8'h0a], shadow[8'h09], shadow[8'h0b],
                 shadow[8'h0c], shadow[8'h0d], shadow[8'h0e]};
        exp_b = {shadow[8'h10][2:0], shadow[8'h11], shadow[8'h12],
                 shadow[8'h13]};
        `CHK(synth_a[47:40], exp_a[47:40])
        `CHK(synth_a[39:32], exp_a[39:32])
        `CHK(synth_a[31:24], exp_a[31:24])
        `CHK(synth_a[23:0], exp_a[23:0])
        `CHK(out_div, shadow[8'h0f])
        `CHK(synth_b, exp_b)
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        i_host.wr(a, d);
        shadow[a] = (shadow[a] & ~wmask(a)) | (d & wmask(a));
        check_outputs();
    endtask
    task automatic get(input logic [7:0] a);
        logic [7:0] d;
        logic       v;
        i_host.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, shadow[a])
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // Defaults, corners and random traffic, twice around a mid-run reset
    initial begin
        void'($urandom(19508));
        reset_bank();
        repeat (2) begin
            check_outputs();
            `CHK(synth_a.fb_integer, 11'h258)
            `CHK(synth_b[26:16], 11'h03c)
            for (int a = 8'h08; a <= 8'h14; a++) get(8'(a));
            put(8'h10, 8'hff);
            get(8'h10);
            put(8'h14, 8'h5a);
            put(8'h08, 8'ha5);
            get(8'h14);
            get(8'h08);
            for (int i = 0; i < 300; i++) begin
                logic [7:0] a;
                a = 8'h08 + 8'($urandom_range(12));
                i_host.idle_cycles = $urandom_range(2);
                if ($urandom_range(1) == 1)
                    put(a, 8'($urandom));
                else
                    get(a);
            end
            @(negedge clock_i);
            reset_bank();
        end
        tally_and_finish();
    end
endmodule
bind pdcb_bank pdcb_bank_monitor i_mon (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o),
    .synth_a_o(synth_a_o), .out_div_o(out_div_o), .synth_b_o(synth_b_o));
